//--- sat_pkg.sv
// shared constants and types of the segment address translation unit
package sat_pkg;

  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned SEG_COUNT  = 6;
  localparam int unsigned SEG_IDX_W  = 3;

  // segment register numbers
  localparam logic [2:0] SEG_ES = 3'h0;
  localparam logic [2:0] SEG_CS = 3'h1;
  localparam logic [2:0] SEG_SS = 3'h2;
  localparam logic [2:0] SEG_DATA = 3'h3;
  localparam logic [2:0] SEG_FS = 3'h4;
  localparam logic [2:0] SEG_GS = 3'h5;

  // selector fields
  localparam int unsigned SEL_PRIV_LO = 0;
  localparam int unsigned SEL_TBL_BIT = 2;
  localparam int unsigned SEL_IDX_LO = 3;
  localparam int unsigned SEL_IDX_HI = 15;
  localparam int unsigned DESC_BYTES_SH = 3;

  // descriptor high word fields
  localparam int unsigned DH_BASE_MID_LO = 0;
  localparam int unsigned DH_TYPE_LO     = 8;
  localparam int unsigned DH_S_BIT       = 12;
  localparam int unsigned DH_DPL_LO      = 13;
  localparam int unsigned DH_P_BIT       = 15;
  localparam int unsigned DH_LIM_HI_LO   = 16;
  localparam int unsigned DH_G_BIT       = 23;
  localparam int unsigned DH_BASE_HI_LO  = 24;

  // segment type bits
  localparam int unsigned TY_CODE_BIT = 3;
  localparam int unsigned TY_RW_BIT   = 1;

  // paging: 4 KByte pages, two-level walk
  localparam int unsigned PAGE_SH    = 12;
  localparam int unsigned DIR_SH     = 22;
  localparam int unsigned PTE_P_BIT  = 0;

  localparam logic [31:0] RESET_FETCH   = 32'hFFFF_FFF0;
  localparam logic [31:0] CS_RESET_BASE = 32'hFFFF_0000;
  localparam logic [31:0] SEG_RESET_LIM = 32'h0000_FFFF;
  localparam logic [3:0]  TY_CODE_RX    = 4'hA;
  localparam logic [3:0]  TY_DATA_RW    = 4'h2;

  typedef struct packed {
    logic [15:0] sel;
    logic        usable;
    logic [31:0] base;
    logic [31:0] limit;
    logic [3:0]  seg_type;
    logic        s_flag;
    logic [1:0]  dpl;
  } sat_seg_t;

  localparam sat_seg_t CS_RESET  = '{16'hF000, 1'b1, CS_RESET_BASE, SEG_RESET_LIM, TY_CODE_RX, 1'b1, 2'h0};
  localparam sat_seg_t SEG_RESET = '{16'h0000, 1'b1, 32'h0000_0000, SEG_RESET_LIM, TY_DATA_RW, 1'b1, 2'h0};

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DESC_LO = 3'b001,
    ST_DESC_HI = 3'b010,
    ST_CHECK   = 3'b011,
    ST_PDE     = 3'b100,
    ST_PTE     = 3'b101,
    ST_DATA    = 3'b110
  } sat_state_t;

endpackage

//--- sat_seg_cache.sv
// register file holding the cached segment descriptors, registered read
`timescale 1ns/1ps
module sat_seg_cache
  import sat_pkg::*;
#(
  parameter int unsigned DEPTH = SEG_COUNT
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic [SEG_IDX_W-1:0] rd_idx,
  output sat_seg_t                  rd_data,
  input  wire logic                 wr_en,
  input  wire logic [SEG_IDX_W-1:0] wr_idx,
  input  sat_seg_t                  wr_data
);

  initial begin
    if (DEPTH < 2 || DEPTH > (1 << SEG_IDX_W)) $error("sat_seg_cache: bad depth");
  end

  sat_seg_t mem [DEPTH];
  sat_seg_t next_rd_data;

  // read data registered so the check stage sees a stable entry
  always_comb begin
    next_rd_data = mem[rd_idx];
  end

  // reset leaves code segment at the top of memory and data segments at base 0
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= (i == int'(SEG_CS)) ? CS_RESET : SEG_RESET;
      end
      rd_data <= SEG_RESET;
    end else begin
      if (wr_en) begin
        mem[wr_idx] <= wr_data;
      end
      rd_data <= next_rd_data;
    end
  end

endmodule

//--- sat_unit.sv
// segment translation, protection checks and optional two-level paging
`timescale 1ns/1ps

// Overview of operation
// - linear address equals descriptor base plus access offset
// - segment translation always applies; no bypass input exists
// - paging off: linear address goes straight onto the bus
// - paging on: walk directory and table before the data cycle
// - not-present directory or table entry aborts with page fault
// - pages are 4 KBytes, each mapped independently
// - descriptor gives limit, rights, privilege, type and base
// - operations the segment type forbids are refused
// - offset beyond limit raises general protection fault
// - a 4 GByte limit never faults on range
// - after reset fetching starts near the top of memory
// - after reset the data segment base is zero
// - privilege 0 supervisor and 3 user descriptors; 0 most privileged
// - descriptor address is table base plus index times 8
// - table select bit 2 picks global or local table
// - null in data register loads fine, faults on use; code/stack load faults
module sat_unit
  import sat_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // core side
  input  wire logic                 load_req,
  input  wire logic [SEG_IDX_W-1:0] load_seg,
  input  wire logic [15:0]          load_sel,
  input  wire logic                 acc_req,
  input  wire logic [SEG_IDX_W-1:0] acc_seg,
  input  wire logic [31:0]          acc_offset,
  input  wire logic                 acc_write,
  input  wire logic                 acc_exec,
  input  wire logic [31:0]          acc_wdata,
  input  wire logic [1:0]           cpl,
  input  wire logic                 paging_en,
  input  wire logic [31:0]          page_dir_base,
  input  wire logic [31:0]          global_descriptor_table_base,
  input  wire logic [31:0]          local_descriptor_table_base,
  output logic                      ready,
  output logic                      done,
  output logic                      general_protection_fault,
  output logic                      page_fault,
  output logic [31:0]               fault_addr,
  output logic [31:0]               acc_rdata,
  output logic [31:0]               start_addr,
  // memory bus
  output logic                      mem_req,
  output logic                      mem_we,
  output logic [ADDR_W-1:0]         mem_addr,
  output logic [31:0]               mem_wdata,
  input  wire logic                 mem_ack,
  input  wire logic [31:0]          mem_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // state

  sat_state_t           state, next_state;
  logic                 next_ready, next_done, next_prot, next_pf;
  logic [31:0]          next_fault_addr, next_acc_rdata;
  logic                 next_mem_req, next_mem_we;
  logic [ADDR_W-1:0]    next_mem_addr;
  logic [31:0]          next_mem_wdata;
  logic [SEG_IDX_W-1:0] op_seg, next_op_seg;
  logic [31:0]          op_offset, next_op_offset;
  logic                 op_write, next_op_write;
  logic                 op_exec, next_op_exec;
  logic [31:0]          op_wdata, next_op_wdata;
  logic [15:0]          op_sel, next_op_sel;
  logic [31:0]          desc_lo, next_desc_lo;
  logic [31:0]          lin, next_lin;

  logic [SEG_IDX_W-1:0] rd_idx;
  sat_seg_t             cur;
  logic                 wr_en;
  logic [SEG_IDX_W-1:0] wr_idx;
  sat_seg_t             wr_data;

  sat_seg_cache #(
    .DEPTH (SEG_COUNT)
  ) u_cache (
    .ref_clk (ref_clk),
    .rst     (rst),
    .rd_idx  (rd_idx),
    .rd_data (cur),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // null means index 0 in the global table; requested privilege is ignored
  function automatic logic is_null(input logic [15:0] sel);
    return (sel[SEL_IDX_HI:SEL_TBL_BIT] == 14'h0000);
  endfunction

  // expand a 20-bit limit by granularity
  function automatic logic [31:0] eff_limit(input logic [19:0] lim, input logic g);
    return g ? {lim, 12'hFFF} : {12'h000, lim};
  endfunction

  // type and privilege check of the cached entry for the pending operation
  function automatic logic rights_bad(input sat_seg_t e, input logic wr, input logic ex,
                                      input logic [1:0] pl, input logic [1:0] req_pl);
    logic code;
    logic [1:0] eff;
    code = e.seg_type[TY_CODE_BIT];
    eff  = (pl > req_pl) ? pl : req_pl;
    if (!e.s_flag) return 1'b1;
    if (code) return wr || (!ex && !e.seg_type[TY_RW_BIT]);
    return ex || (wr && !e.seg_type[TY_RW_BIT]) || (eff > e.dpl);
  endfunction

  logic [31:0] desc_addr;
  logic [31:0] hi;
  logic [31:0] lin_sum;
  logic        limit_bad;

  // table select and index scaling of the pending selector
  assign desc_addr = (op_sel[SEL_TBL_BIT] ? local_descriptor_table_base : global_descriptor_table_base)
                   + {16'h0000, op_sel[SEL_IDX_HI:SEL_IDX_LO], 3'b000};
  assign hi        = mem_rdata;
  assign lin_sum   = cur.base + op_offset;
  // full 4 GByte limit can never be exceeded by a 32-bit offset
  assign limit_bad = (op_offset > cur.limit);
  assign rd_idx    = (state == ST_IDLE) ? acc_seg : op_seg;
  // a null load writes in the taking cycle, before op_seg has caught up
  assign wr_idx    = (state == ST_IDLE) ? load_seg : op_seg;

  ////////////////////////////////////////////////////////////////////////
  // sequencer next values

  always_comb begin
    next_state      = state;
    next_ready      = 1'b0;
    next_done       = 1'b0;
    next_prot       = 1'b0;
    next_pf         = 1'b0;
    next_fault_addr = fault_addr;
    next_acc_rdata  = acc_rdata;
    next_mem_req    = mem_req;
    next_mem_we     = mem_we;
    next_mem_addr   = mem_addr;
    next_mem_wdata  = mem_wdata;
    next_op_seg     = op_seg;
    next_op_offset  = op_offset;
    next_op_write   = op_write;
    next_op_exec    = op_exec;
    next_op_wdata   = op_wdata;
    next_op_sel     = op_sel;
    next_desc_lo    = desc_lo;
    next_lin        = lin;
    wr_en           = 1'b0;
    wr_data         = SEG_RESET;
    unique case (state)
      ST_IDLE: begin
        // a load wins over an access offered in the same cycle
        // nothing is taken while ready is low, i.e. in the first cycle after reset
        if (load_req && ready) begin
          next_op_seg = load_seg;
          next_op_sel = load_sel;
          if (is_null(load_sel)) begin
            if (load_seg == SEG_CS || load_seg == SEG_SS) begin
              next_prot = 1'b1;
              next_done = 1'b1;
              next_ready = 1'b1;
            end else begin
              wr_en          = 1'b1;
              wr_data        = SEG_RESET;
              wr_data.sel    = load_sel;
              wr_data.usable = 1'b0;
              next_done      = 1'b1;
              next_ready     = 1'b1;
            end
            next_op_seg = load_seg;
          end else begin
            next_state    = ST_DESC_LO;
            next_mem_req  = 1'b1;
            next_mem_we   = 1'b0;
            next_mem_addr = (load_sel[SEL_TBL_BIT] ? local_descriptor_table_base : global_descriptor_table_base)
                          + {16'h0000, load_sel[SEL_IDX_HI:SEL_IDX_LO], 3'b000};
          end
        end else if (acc_req && ready) begin
          // every access goes through the segment stage
          next_op_seg    = acc_seg;
          next_op_offset = acc_offset;
          next_op_write  = acc_write;
          next_op_exec   = acc_exec;
          next_op_wdata  = acc_wdata;
          next_state     = ST_CHECK;
        end else begin
          next_ready = 1'b1;
        end
      end
      ST_DESC_LO: begin
        if (mem_ack) begin
          next_desc_lo  = mem_rdata;
          next_mem_addr = desc_addr + 32'h0000_0004;
          next_state    = ST_DESC_HI;
        end
      end
      ST_DESC_HI: begin
        if (mem_ack) begin
          next_mem_req = 1'b0;
          next_done    = 1'b1;
          next_ready   = 1'b1;
          next_state   = ST_IDLE;
          if (!hi[DH_P_BIT]) begin
            next_prot       = 1'b1;
            next_fault_addr = desc_addr;
          end else begin
            wr_en            = 1'b1;
            wr_data.sel      = op_sel;
            wr_data.usable   = 1'b1;
            wr_data.base     = {hi[DH_BASE_HI_LO +: 8], hi[DH_BASE_MID_LO +: 8], desc_lo[31:16]};
            wr_data.limit    = eff_limit({hi[DH_LIM_HI_LO +: 4], desc_lo[15:0]}, hi[DH_G_BIT]);
            wr_data.seg_type = hi[DH_TYPE_LO +: 4];
            wr_data.s_flag   = hi[DH_S_BIT];
            wr_data.dpl      = hi[DH_DPL_LO +: 2];
          end
        end
      end
      ST_CHECK: begin
        // checks settle before the linear address is used anywhere
        if (!cur.usable || limit_bad
            || rights_bad(cur, op_write, op_exec, cpl, cur.sel[SEL_PRIV_LO +: 2])) begin
          next_prot       = 1'b1;
          next_fault_addr = op_offset;
          next_done       = 1'b1;
          next_ready      = 1'b1;
          next_state      = ST_IDLE;
        end else begin
          next_lin     = lin_sum;
          next_mem_req = 1'b1;
          if (paging_en) begin
            next_mem_we   = 1'b0;
            next_mem_addr = {page_dir_base[31:PAGE_SH], lin_sum[31:DIR_SH], 2'b00};
            next_state    = ST_PDE;
          end else begin
            next_mem_we    = op_write;
            next_mem_addr  = lin_sum;
            next_mem_wdata = op_wdata;
            next_state     = ST_DATA;
          end
        end
      end
      ST_PDE, ST_PTE: begin
        if (mem_ack) begin
          if (!mem_rdata[PTE_P_BIT]) begin
            next_mem_req    = 1'b0;
            next_pf         = 1'b1;
            next_fault_addr = lin;
            next_done       = 1'b1;
            next_ready      = 1'b1;
            next_state      = ST_IDLE;
          end else if (state == ST_PDE) begin
            next_mem_addr = {mem_rdata[31:PAGE_SH], lin[DIR_SH-1:PAGE_SH], 2'b00};
            next_state    = ST_PTE;
          end else begin
            next_mem_we    = op_write;
            next_mem_addr  = {mem_rdata[31:PAGE_SH], lin[PAGE_SH-1:0]};
            next_mem_wdata = op_wdata;
            next_state     = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (mem_ack) begin
          next_mem_req   = 1'b0;
          next_mem_we    = 1'b0;
          next_acc_rdata = op_write ? acc_rdata : mem_rdata;
          next_done      = 1'b1;
          next_ready     = 1'b1;
          next_state     = ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state                    <= ST_IDLE;
      ready                    <= 1'b0;
      done                     <= 1'b0;
      general_protection_fault <= 1'b0;
      page_fault               <= 1'b0;
      fault_addr               <= 32'h0000_0000;
      acc_rdata                <= 32'h0000_0000;
      start_addr               <= RESET_FETCH;
      mem_req                  <= 1'b0;
      mem_we                   <= 1'b0;
      mem_addr                 <= 32'h0000_0000;
      mem_wdata                <= 32'h0000_0000;
      op_seg                   <= SEG_DATA;
      op_offset                <= 32'h0000_0000;
      op_write                 <= 1'b0;
      op_exec                  <= 1'b0;
      op_wdata                 <= 32'h0000_0000;
      op_sel                   <= 16'h0000;
      desc_lo                  <= 32'h0000_0000;
      lin                      <= 32'h0000_0000;
    end else begin
      state                    <= next_state;
      ready                    <= next_ready;
      done                     <= next_done;
      general_protection_fault <= next_prot;
      page_fault               <= next_pf;
      fault_addr               <= next_fault_addr;
      acc_rdata                <= next_acc_rdata;
      start_addr               <= RESET_FETCH;
      mem_req                  <= next_mem_req;
      mem_we                   <= next_mem_we;
      mem_addr                 <= next_mem_addr;
      mem_wdata                <= next_mem_wdata;
      op_seg                   <= next_op_seg;
      op_offset                <= next_op_offset;
      op_write                 <= next_op_write;
      op_exec                  <= next_op_exec;
      op_wdata                 <= next_op_wdata;
      op_sel                   <= next_op_sel;
      desc_lo                  <= next_desc_lo;
      lin                      <= next_lin;
    end
  end

endmodule

//--- sat_unit_assertions.sv
// concurrent checks on the ports of the segment address translation unit
`timescale 1ns/1ps
module sat_unit_assertions
  import sat_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        load_req,
  input wire logic        acc_req,
  input wire logic        paging_en,
  input wire logic [31:0] page_dir_base,
  input wire logic        ready,
  input wire logic        done,
  input wire logic        general_protection_fault,
  input wire logic        page_fault,
  input wire logic [31:0] start_addr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // requests are taken only while idle; load wins over access
  sequence s_take;
    ready && (load_req || acc_req);
  endsequence
  sequence s_take_acc;
    ready && acc_req && !load_req;
  endsequence
  sequence s_paged_take;
    s_take_acc ##1 paging_en;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_start_fixed: assert property (start_addr == RESET_FETCH)
    else $error("fetch start address wrong");
  // the check cycle sits between the take and any bus cycle
  chk_check_first: assert property (s_take_acc |=> (!ready && !mem_req && !done) ##1
    (mem_req || (done && general_protection_fault))) else $error("access did not pass the check cycle");
  chk_fault_no_bus: assert property (general_protection_fault |-> done && !mem_req)
    else $error("protection fault with a bus cycle or without done");
  chk_page_fault_end: assert property (page_fault |-> done && !general_protection_fault && !mem_req)
    else $error("page fault not reported cleanly");
  // done repeats only when a null load is taken in the done cycle itself
  chk_done_pulse: assert property (done |-> (ready && !mem_req) ##1 (!done || $past(load_req)))
    else $error("done not a single pulse ending in idle");
  chk_bus_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("bus request changed before acknowledge");
  chk_bus_end: assert property ($fell(mem_req) |-> done)
    else $error("bus released without completion");
  // a paged access starts its walk at the directory entry
  chk_dir_fetch: assert property (s_paged_take |=> general_protection_fault || (mem_req && !mem_we &&
    mem_addr[31:12] == page_dir_base[31:12] && mem_addr[1:0] == 2'h0)) else $error("walk start address wrong");
  chk_done_bound: assert property (s_take |-> ##[1:60] done)
    else $error("request never completed");
endmodule

//--- sat_mem_model.sv
// behavioural memory on the unit's bus, answering promptly or slowly
`timescale 1ns/1ps
module sat_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  int          wait_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // unwritten words read as the inverted address, so a wrong address shows in the data
  always @(posedge ref_clk) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_cnt  <= 0;
    end else if (mem_req && !mem_ack && wait_cnt >= (slow ? 3 : 0)) begin
      mem_ack   <= 1'b1;
      wait_cnt  <= 0;
      if (mem_we) mem[mem_addr] = mem_wdata;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
    end else begin
      mem_ack   <= 1'b0;
      wait_cnt  <= mem_req ? wait_cnt + 1 : 0;
      mem_rdata <= ~mem_rdata; // data flips every cycle outside the acknowledge cycle, so it is only valid while mem_ack is high
    end
  end
endmodule

//--- segment_address_translation_test.sv
// self-checking bench for the segment address translation unit
`timescale 1ns/1ps
module segment_address_translation_test;
  import sat_pkg::*;
  typedef struct { logic gpf; logic pf; logic chk; logic [31:0] rd; } sat_note_t;
  logic        ref_clk, rst, load_req, acc_req, acc_write, acc_exec, paging_en, slow;
  logic        ready, done, general_protection_fault, page_fault, mem_req, mem_we, mem_ack;
  logic [2:0]  load_seg, acc_seg;
  logic [15:0] load_sel;
  logic [1:0]  cpl;
  logic [31:0] acc_offset, acc_wdata, page_dir_base, fault_addr, acc_rdata;
  logic [31:0] global_descriptor_table_base, local_descriptor_table_base;
  logic [31:0] start_addr, mem_addr, mem_wdata, mem_rdata, rnd, wd, off;
  int          n_errors, tests_run;
  sat_note_t   notes[$];
  sat_note_t   note;

  sat_unit DUT (.ref_clk, .rst, .load_req, .load_seg, .load_sel, .acc_req, .acc_seg, .acc_offset,
    .acc_write, .acc_exec, .acc_wdata, .cpl, .paging_en, .page_dir_base, .global_descriptor_table_base,
    .local_descriptor_table_base, .ready,
    .done, .general_protection_fault, .page_fault, .fault_addr, .acc_rdata, .start_addr, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  sat_mem_model mem_model (.ref_clk, .rst, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  // shared compare, verdict and random source
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // one request held up to its taking edge, then a bounded wait for done
  task automatic issue(input logic is_load, input sat_note_t n);
    int k;
    notes.push_back(n);
    rnd = lfsr_next(rnd);
    slow = rnd[5];
    k = 0;
    while (ready !== 1'b1 && k < 100) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (is_load) load_req = 1'b1;
    else acc_req = 1'b1;
    @(posedge ref_clk);
    #1;
    load_req = 1'b0;
    acc_req = 1'b0;
    while (done !== 1'b1 && k < 200) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 200) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic acc(input logic [2:0] seg, input logic [31:0] o, input logic wr, input logic ex,
                     input logic gpf, input logic pf, input logic [31:0] rd);
    acc_seg = seg;
    acc_offset = o;
    acc_write = wr;
    acc_exec = ex;
    acc_wdata = rnd;
    issue(1'b0, '{gpf, pf, gpf || pf || !wr, rd});
  endtask
  task automatic ld(input logic [2:0] seg, input logic [15:0] sel, input logic gpf);
    load_seg = seg;
    load_sel = sel;
    issue(1'b1, '{gpf, 1'b0, 1'b0, 32'h0000_0000});
  endtask
  // descriptor as two words: base, limit, granularity, type, privilege, present
  task automatic put_desc(input logic [31:0] tbl, input logic [12:0] idx, input logic [31:0] b,
                          input logic [19:0] lim, input logic g, input logic [3:0] ty, input logic [1:0] dpl,
                          input logic p);
    mem_model.mem[tbl + {16'h0000, idx, 3'b000}] = {b[15:0], lim[15:0]};
    mem_model.mem[tbl + {16'h0000, idx, 3'b100}] = {b[31:24], g, 3'b000, lim[19:16], p, dpl, 1'b1, ty, b[23:16]};
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // oldest note against each completed request; the results hold past done
  always @(posedge ref_clk) begin
    if (!rst && done === 1'b1) begin
      if (notes.size() == 0) check(32'h0000_0001, 32'h0000_0000);
      else begin
        note = notes.pop_front();
        check({31'h0, general_protection_fault}, {31'h0, note.gpf});
        check({31'h0, page_fault}, {31'h0, note.pf});
        if (note.chk && (note.gpf || note.pf)) check(fault_addr, note.rd);
        else if (note.chk) check(acc_rdata, note.rd);
      end
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // main sequence: reset state, null selectors, both tables, limits, rights, paging
  initial begin
    {rst, load_req, acc_req, acc_write, acc_exec, paging_en, slow} = 7'b1000000;
    {load_seg, acc_seg, load_sel, cpl, acc_offset, acc_wdata} = '0;
    global_descriptor_table_base = 32'h0001_0000;
    local_descriptor_table_base = 32'h0002_0000;
    page_dir_base = 32'h0003_0000;
    rnd = 32'h1496;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check(start_addr, 32'hFFFF_FFF0);
    acc(SEG_DATA, 32'h0000_0100, 1'b0, 1'b0, 1'b0, 1'b0, ~32'h0000_0100);
    acc(SEG_CS, 32'h0000_0010, 1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0010);
    acc(SEG_DATA, 32'h0000_0010, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0010);
    acc(SEG_ES, 32'h0001_0000, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0001_0000);
    cpl = 2'h3;
    acc(SEG_ES, 32'h0000_0000, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_0000);
    cpl = 2'h0;
    ld(SEG_DATA, 16'h0000, 1'b0);
    acc(SEG_DATA, 32'h0000_0100, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_0100);
    ld(SEG_CS, 16'h0000, 1'b1);
    ld(SEG_SS, 16'h0000, 1'b1);
    put_desc(global_descriptor_table_base, 13'd5, 32'h0010_0000, 20'h0_0FFF, 1'b0, 4'h2, 2'h3, 1'b1);
    put_desc(local_descriptor_table_base, 13'd5, 32'h0020_0000, 20'h0_0FFF, 1'b0, 4'h2, 2'h3, 1'b1);
    put_desc(global_descriptor_table_base, 13'd6, 32'h0030_0000, 20'h0_0FFF, 1'b0, 4'h0, 2'h3, 1'b1);
    put_desc(global_descriptor_table_base, 13'd7, 32'h0000_0000, 20'hF_FFFF, 1'b1, 4'h2, 2'h3, 1'b1);
    put_desc(global_descriptor_table_base, 13'd9, 32'h0000_0000, 20'h0_0000, 1'b0, 4'h2, 2'h0, 1'b0);
    ld(SEG_DATA, 16'h0028, 1'b0);
    ld(SEG_ES, 16'h002C, 1'b0);
    ld(SEG_FS, 16'h0038, 1'b0);
    ld(SEG_GS, 16'h0048, 1'b1);
    ld(SEG_GS, 16'h0030, 1'b0);
    acc(SEG_ES, 32'h0000_0010, 1'b0, 1'b0, 1'b0, 1'b0, ~32'h0020_0010);
    acc(SEG_DATA, 32'h0000_0FFF, 1'b0, 1'b0, 1'b0, 1'b0, ~32'h0010_0FFF);
    acc(SEG_DATA, 32'h0000_1000, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_1000);
    for (int i = 0; i < 6; i++) begin
      off = {20'h0_0000, rnd[11:0]};
      acc(SEG_DATA, off, 1'b0, 1'b0, 1'b0, 1'b0, ~(32'h0010_0000 + off));
    end
    wd = rnd;
    acc(SEG_DATA, 32'h0000_0020, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
    acc(SEG_DATA, 32'h0000_0020, 1'b0, 1'b0, 1'b0, 1'b0, wd);
    acc(SEG_GS, 32'h0000_0020, 1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0020);
    cpl = 2'h3;
    acc(SEG_FS, 32'hFFFF_FFF0, 1'b0, 1'b0, 1'b0, 1'b0, ~32'hFFFF_FFF0);
    cpl = 2'h0;
    // directory entry 2 -> table 0004_0000; entries 2, 3 present, 4 absent; directory entry 3 absent
    mem_model.mem[32'h0003_0008] = 32'h0004_0001;
    mem_model.mem[32'h0003_000C] = 32'h0006_0000;
    mem_model.mem[32'h0004_0008] = 32'h0007_7001;
    mem_model.mem[32'h0004_000C] = 32'h0009_9001;
    mem_model.mem[32'h0004_0010] = 32'h0005_5000;
    paging_en = 1'b1;
    acc(SEG_FS, 32'h0080_2345, 1'b0, 1'b0, 1'b0, 1'b0, ~32'h0007_7345);
    acc(SEG_FS, 32'h0080_3345, 1'b0, 1'b0, 1'b0, 1'b0, ~32'h0009_9345);
    acc(SEG_FS, 32'h0080_4000, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0080_4000);
    acc(SEG_FS, 32'h00C0_0000, 1'b0, 1'b0, 1'b0, 1'b1, 32'h00C0_0000);
    acc(SEG_DATA, 32'h0000_1000, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_1000);
    repeat (2) @(posedge ref_clk);
    report_and_stop();
  end
endmodule

bind sat_unit sat_unit_assertions chk (.ref_clk, .rst, .load_req, .acc_req, .paging_en, .page_dir_base,
  .ready, .done, .general_protection_fault, .page_fault, .start_addr, .mem_req, .mem_we, .mem_addr, .mem_ack);
